// File: dv/hsc_bus_peer.sv
// bus peer model: measures the scl phase lengths seen on the wire
`timescale 1ns/100ps
module hsc_bus_peer (
   input  wire logic        clk_in,
   input  wire logic        scl_in,
   output logic      [15:0] high_len_out,
   output logic      [15:0] low_len_out
);
   logic [15:0] run_r  = 16'h0000;
   logic        last_r = 1'b1;
   // cycles per phase
   // a phase length is only known once the following edge arrives
   always @(posedge clk_in) begin
      if (scl_in === last_r) begin
         run_r <= run_r + 16'h0001;
      end else begin
         if (last_r === 1'b1) begin
            high_len_out <= run_r;
         end
         if (last_r === 1'b0) begin
            low_len_out <= run_r;
         end
         run_r <= 16'h0001;
      end
      last_r <= scl_in;
   end
endmodule : hsc_bus_peer

// File: dv/hsc_counts_bench.sv
// self-checking bench for the high-speed scl count registers
`timescale 1ns/100ps
module hsc_counts_bench;
   import hsc_pkg::*;
   logic clk_in = 1'b0, rst_in = 1'b1, sel = 1'b0, wr = 1'b0;
   logic en = 1'b0, hs_act = 1'b0, hdr_done = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [31:0] wdata = 32'h00000000, rdata, got;
   logic        scl;
   hsc_cnt_t    hi_f, lo_f, peer_hi, peer_lo;
   int          n_errors = 0, total_checks = 0;
   always #20 clk_in = ~clk_in;
   hsc_counts hsc_counts_i (.clk_in(clk_in), .rst_in(rst_in),
      .reg_sel_in(sel), .reg_wr_in(wr), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_rdata_out(rdata),
      .controller_enable_reg_in(en), .hs_active_in(hs_act),
      .hs_header_done_in(hdr_done), .fast_clock_high_count_in(16'h0009),
      .fast_clock_low_count_in(16'h000b), .scl_out(scl),
      .hs_high_count_field_out(hi_f), .hs_low_count_field_out(lo_f));
   hsc_bus_peer hsc_bus_peer_i (.clk_in(clk_in), .scl_in(scl),
      .high_len_out(peer_hi), .low_len_out(peer_lo));
   //------------------------------------------------------------
   // shared tasks
   //------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // whole word per access, so byte order never arises
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_in);
      #1 {sel, wr, addr, wdata} = {1'b1, 1'b1, a, d};
      @(posedge clk_in);
      #1 {sel, wr} = 2'b00;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_in);
      #1 {sel, wr, addr} = {1'b1, 1'b0, a};
      @(posedge clk_in);
      got = rdata;
      #1 sel = 1'b0;
   endtask : rd_reg
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   // waits under a bound until the peer sees the wanted phase lengths
   task automatic wait_len(input hsc_cnt_t h, input hsc_cnt_t l);
      int i;
      for (i = 0; i < 300 && !(peer_hi === h && peer_lo === l); i++) begin
         @(posedge clk_in);
      end
      check({peer_hi, peer_lo}, {h, l});
      if (i == 300) final_report();
   endtask : wait_len
   //------------------------------------------------------------
   // scenarios
   //------------------------------------------------------------
   task automatic t_reset;
      rd_reg(8'h24);
      check(got, 32'h00000008);
      rd_reg(8'h28);
      check(got, 32'h00000014);
      rd_reg(8'h2c);
      check(got, 32'h00000000);
      $display("test reset values done");
   endtask : t_reset
   task automatic t_clamp;
      wr_reg(8'h24, 32'h00000005);
      wr_reg(8'h28, 32'h00000007);
      check({hi_f, lo_f}, 32'h00060008);
      wr_reg(8'h24, 32'hffff0006);
      wr_reg(8'h28, 32'h5a5a0008);
      rd_reg(8'h24);
      check(got, 32'h00000006);
      rd_reg(8'h28);
      check(got, 32'h00000008);
      $display("test clamp done");
   endtask : t_clamp
   task automatic t_lock;
      @(posedge clk_in);
      #1 en = 1'b1;
      wr_reg(8'h24, 32'h00000033);
      wr_reg(8'h28, 32'h00000044);
      check({hi_f, lo_f}, 32'h00060008);
      @(posedge clk_in);
      #1 en = 1'b0;
      wr_reg(8'h24, 32'h0000000a);
      wr_reg(8'h28, 32'h0000000c);
      check({hi_f, lo_f}, 32'h000a000c);
      $display("test enable lock done");
   endtask : t_lock
   // counts are programmed before the transfer starts
   // the timer only runs while the controller is enabled
   task automatic t_timing;
      @(posedge clk_in);
      #1 {en, hs_act} = 2'b11;
      wait_len(16'h0009, 16'h000b);
      @(posedge clk_in);
      #1 hdr_done = 1'b1;
      wait_len(16'h000a, 16'h000c);
      check({hi_f, lo_f}, 32'h000a000c);
      // shortest legal high phase, reprogrammed while disabled
      @(posedge clk_in);
      #1 en = 1'b0;
      wr_reg(8'h24, 32'h00000006);
      @(posedge clk_in);
      #1 en = 1'b1;
      wait_len(16'h0006, 16'h000c);
      $display("test phase timing done");
   endtask : t_timing
   initial begin
      repeat (3) @(posedge clk_in);
      #1 rst_in = 1'b0;
      t_reset();
      t_clamp();
      t_lock();
      t_timing();
      final_report();
   end
endmodule : hsc_counts_bench

// File: pkg/hsc_cnt_if.sv
// carrier between the register file and the phase timer
`timescale 1ns/100ps
interface hsc_cnt_if;
   logic [15:0] high_cnt;
   logic [15:0] low_cnt;
   logic        run;
   logic        scl;
   modport regs  (output high_cnt, output low_cnt, output run, input scl);
   modport timer (input high_cnt, input low_cnt, input run, output scl);
endinterface : hsc_cnt_if

// File: pkg/hsc_pkg.sv
// types shared by the high-speed count block
package hsc_pkg;
   typedef logic [15:0] hsc_cnt_t;
   typedef enum logic [1:0] {
      HSC_SPEED_STD  = 2'h1,
      HSC_SPEED_FAST = 2'h2,
      HSC_SPEED_HIGH = 2'h3
   } hsc_speed_t;
   typedef enum logic {
      HSC_PH_LOW,
      HSC_PH_HIGH
   } hsc_phase_t;
endpackage : hsc_pkg

// File: pkg/hsc_regs.svh
// register offsets, field positions, reset values and limits for hs counts
`ifndef HSC_REGS_SVH
`define HSC_REGS_SVH
`define HSC_HIGH_OFS      8'h24
`define HSC_LOW_OFS       8'h28
`define HSC_CNT_MSB       15
`define HSC_HIGH_RST      16'h0008
`define HSC_LOW_RST       16'h0014
`define HSC_HIGH_MIN      16'h0006
`define HSC_LOW_MIN       16'h0008
`define HSC_SPEED_HIGH    2'h3
`endif

// File: rtl/hsc_counts.sv
// high-speed scl count registers with phase timer
//------------------------------------------------------------
//------------------------------------------------------------
`timescale 1ns/100ps
`include "hsc_regs.svh"
module hsc_counts #(
   parameter logic [1:0] TOP_SPEED_SETTING       = `HSC_SPEED_HIGH,
   parameter bit         HARDCODED_COUNTS_OPTION = 1'b0
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        reg_sel_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic [31:0] reg_wdata_in,
   output logic      [31:0] reg_rdata_out,
   input  wire logic        controller_enable_reg_in,
   input  wire logic        hs_active_in,
   input  wire logic        hs_header_done_in,
   input  wire hsc_pkg::hsc_cnt_t fast_clock_high_count_in,
   input  wire hsc_pkg::hsc_cnt_t fast_clock_low_count_in,
   output logic             scl_out,
   output hsc_pkg::hsc_cnt_t hs_high_count_field_out,
   output hsc_pkg::hsc_cnt_t hs_low_count_field_out
);
   import hsc_pkg::*;

   //------------------------------------------------------------
   // register storage
   //------------------------------------------------------------
   localparam bit HS_PRESENT = (TOP_SPEED_SETTING == `HSC_SPEED_HIGH);

   hsc_cnt_t    high_r;
   hsc_cnt_t    low_r;
   logic        wr_ok;
   logic        wr_high;
   logic        wr_low;
   hsc_cnt_if   cnt_if ();

   // clamp a written value up to its floor
   function automatic hsc_cnt_t clamp_up(input hsc_cnt_t v,
                                         input hsc_cnt_t floor);
      clamp_up = (v < floor) ? floor : v;
   endfunction : clamp_up

   // hardcoded read-only
   // writes while enabled vanish silently; no error is flagged
   assign wr_ok   = reg_sel_in && reg_wr_in && !controller_enable_reg_in
                    && !HARDCODED_COUNTS_OPTION && HS_PRESENT;
   assign wr_high = wr_ok && (reg_addr_in == `HSC_HIGH_OFS);
   assign wr_low  = wr_ok && (reg_addr_in == `HSC_LOW_OFS);

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         high_r <= `HSC_HIGH_RST;
      end else if (wr_high) begin
         high_r <= clamp_up(reg_wdata_in[`HSC_CNT_MSB:0], `HSC_HIGH_MIN);
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         low_r <= `HSC_LOW_RST;
      end else if (wr_low) begin
         low_r <= clamp_up(reg_wdata_in[`HSC_CNT_MSB:0], `HSC_LOW_MIN);
      end
   end

   //------------------------------------------------------------
   // read path
   //------------------------------------------------------------
   // absent reads zero
   always_comb begin
      reg_rdata_out = 32'h0000_0000;
      if (HS_PRESENT && reg_sel_in && !reg_wr_in) begin
         case (reg_addr_in)
            `HSC_HIGH_OFS: reg_rdata_out = {16'h0000, high_r};
            `HSC_LOW_OFS:  reg_rdata_out = {16'h0000, low_r};
            default:       reg_rdata_out = 32'h0000_0000;
         endcase
      end
   end

   // without storage the outputs show zero, as the reads do
   assign hs_high_count_field_out = HS_PRESENT ? high_r : 16'h0000;
   assign hs_low_count_field_out  = HS_PRESENT ? low_r  : 16'h0000;

   //------------------------------------------------------------
   // phase timer feed
   //------------------------------------------------------------
   // fast counts first
   assign cnt_if.high_cnt = (hs_active_in && hs_header_done_in && HS_PRESENT)
                            ? high_r : fast_clock_high_count_in;
   assign cnt_if.low_cnt  = (hs_active_in && hs_header_done_in && HS_PRESENT)
                            ? low_r : fast_clock_low_count_in;
   assign cnt_if.run      = controller_enable_reg_in && hs_active_in;
   assign scl_out         = cnt_if.scl;

   hsc_timer u_timer (
      .clk_in (clk_in),
      .rst_in (rst_in),
      .cnt_if (cnt_if)
   );

   //------------------------------------------------------------
   // checks
   //------------------------------------------------------------
   property p_high_floor;
      @(posedge clk_in) disable iff (rst_in) high_r >= `HSC_HIGH_MIN;
   endproperty
   a_high_floor: assert property (p_high_floor)
      else $error("high count below six");

   property p_low_floor;
      @(posedge clk_in) disable iff (rst_in) low_r >= `HSC_LOW_MIN;
   endproperty
   a_low_floor: assert property (p_low_floor)
      else $error("low count below eight");

   property p_enabled_hold;
      @(posedge clk_in) disable iff (rst_in)
         controller_enable_reg_in |=> $stable(high_r) && $stable(low_r);
   endproperty
   a_enabled_hold: assert property (p_enabled_hold)
      else $error("count changed while enabled");

   property p_high_write;
      @(posedge clk_in) disable iff (rst_in)
         wr_high |=> high_r == clamp_up($past(reg_wdata_in[15:0]),
                                        `HSC_HIGH_MIN);
   endproperty
   a_high_write: assert property (p_high_write)
      else $error("high write not stored");

   property p_low_write;
      @(posedge clk_in) disable iff (rst_in)
         wr_low |=> low_r == clamp_up($past(reg_wdata_in[15:0]),
                                      `HSC_LOW_MIN);
   endproperty
   a_low_write: assert property (p_low_write)
      else $error("low write not stored");

   property p_reserved_zero;
      @(posedge clk_in) disable iff (rst_in)
         reg_rdata_out[31:16] == 16'h0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved bits nonzero");

   property p_absent_zero;
      @(posedge clk_in) disable iff (rst_in)
         !HS_PRESENT |-> reg_rdata_out == 32'h0000_0000;
   endproperty
   a_absent_zero: assert property (p_absent_zero)
      else $error("absent register read nonzero");

   property p_hardcoded;
      @(posedge clk_in) disable iff (rst_in)
         HARDCODED_COUNTS_OPTION |-> high_r == `HSC_HIGH_RST
                                     && low_r == `HSC_LOW_RST;
   endproperty
   a_hardcoded: assert property (p_hardcoded)
      else $error("hardcoded counts changed");

   property p_header_fast;
      @(posedge clk_in) disable iff (rst_in)
         !hs_header_done_in |-> cnt_if.high_cnt == fast_clock_high_count_in;
   endproperty
   a_header_fast: assert property (p_header_fast)
      else $error("header not on fast count");

   // shortest high phase
   // the phase is loaded one edge before scl is seen high, so the count
   // is taken from that edge; a restart after a stop is left out
   sequence s_high_starts;
      cnt_if.run && $past(cnt_if.run) && $rose(cnt_if.scl)
         && $past(cnt_if.high_cnt) == `HSC_HIGH_MIN;
   endsequence
   property p_high_len;
      @(posedge clk_in) disable iff (rst_in)
         s_high_starts ##1 cnt_if.run [*5] |-> cnt_if.scl ##1 !cnt_if.scl;
   endproperty
   a_high_len: assert property (p_high_len)
      else $error("high phase length wrong");
endmodule : hsc_counts

// File: rtl/hsc_timer.sv
// scl phase timer: holds each phase for the programmed number of cycles
`timescale 1ns/100ps
module hsc_timer (
   input  wire logic clk_in,
   input  wire logic rst_in,
   hsc_cnt_if.timer  cnt_if
);
   import hsc_pkg::*;

   hsc_phase_t  phase_r;
   logic [15:0] left_r;

   // counted core cycles
   // count down the current phase; reload with the other phase's length
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         phase_r <= HSC_PH_HIGH;
         left_r  <= 16'h0001;
      end else if (!cnt_if.run) begin
         phase_r <= HSC_PH_HIGH;
         left_r  <= 16'h0001;
      end else if (left_r <= 16'h0001) begin
         case (phase_r)
            HSC_PH_HIGH: begin
               phase_r <= HSC_PH_LOW;
               left_r  <= cnt_if.low_cnt;
            end
            default: begin
               phase_r <= HSC_PH_HIGH;
               left_r  <= cnt_if.high_cnt;
            end
         endcase
      end else begin
         left_r <= left_r - 16'h0001;
      end
   end

   assign cnt_if.scl = (phase_r == HSC_PH_HIGH);
endmodule : hsc_timer
